// ==== pkg/dma_sync_pkg.sv ====
// Shared types and constants for the DMA channel sync controller.
// Assumes one clock domain (core_clk, 200 MHz) and asynchronous active-high reset.
package dma_sync_pkg;

    // ************************************************************
    // Sync modes
    // ************************************************************
    localparam logic [1:0] SYNC_NONE = 2'h0;
    localparam logic [1:0] SYNC_SRC = 2'h1;
    localparam logic [1:0] SYNC_DST = 2'h2;
    localparam logic [1:0] SYNC_BOTH = 2'h3;

    localparam int INT_SRC_WIDTH = 4;
    localparam int DATA_WIDTH = 32;
    localparam int ADDR_WIDTH = 24;
    localparam int BUF_DEPTH = 2;

    // ************************************************************
    // Carriers
    // ************************************************************
    // One word moving from the read phase to the write phase
    typedef struct packed {
        logic [ADDR_WIDTH-1:0] addr;
        logic [DATA_WIDTH-1:0] data;
    } xfer_word_t;

    // Memory access request toward the arbiter
    typedef struct packed {
        logic req;
        logic [ADDR_WIDTH-1:0] addr;
        logic [DATA_WIDTH-1:0] data;
    } mem_req_t;

    // Busy flags of the higher-priority pipeline units
    typedef struct packed {
        logic execute;
        logic read;
        logic decode;
        logic fetch;
    } unit_busy_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_WAIT_RD_INT,
        ST_READ,
        ST_WAIT_WR_INT,
        ST_WRITE
    } phase_t;

endpackage : dma_sync_pkg

// ==== rtl/xfer_buffer.sv ====
// Two-entry valid/ready buffer between the read and write phases.
// Assumes a single clock; both sides may stall independently.
module xfer_buffer
    import dma_sync_pkg::*;
#(
    parameter int DEPTH = BUF_DEPTH
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic inValid,
    output logic inReady,
    input wire xfer_word_t inWord,
    output logic outValid,
    input wire logic outReady,
    output xfer_word_t outWord
);

    initial begin
        if (DEPTH != 2) $error("xfer_buffer supports DEPTH of 2 only");
    end

    typedef struct packed {
        xfer_word_t [1:0] mem;
        logic rdPtr;
        logic wrPtr;
        logic [1:0] count;
    } buf_state_t;

    buf_state_t state_q;
    buf_state_t state_d;
    logic push;
    logic pop;

    // ************************************************************
    // Next state
    // ************************************************************
    // Full and empty derive from the count, so they never lie
    always_comb begin
        state_d = state_q;
        push = inValid && (state_q.count != 2'h2);
        pop = outReady && (state_q.count != 2'h0);
        if (push) begin
            state_d.mem[state_q.wrPtr] = inWord;
            state_d.wrPtr = ~state_q.wrPtr;
        end
        if (pop) begin
            state_d.rdPtr = ~state_q.rdPtr;
        end
        if (push && !pop) begin
            state_d.count = state_q.count + 2'h1;
        end else if (pop && !push) begin
            state_d.count = state_q.count - 2'h1;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign inReady = (state_q.count != 2'h2);
    assign outValid = (state_q.count != 2'h0);
    assign outWord = state_q.mem[state_q.rdPtr];

endmodule : xfer_buffer

// ==== rtl/dma_sync_ctrl.sv ====
// DMA channel sync controller: gates read and write phases on interrupts.
// Assumes inputs synchronous to core_clk; memory grants come from the arbiter.
// Word storage between phases is the two-entry xfer_buffer.

// Contract
// RL1: Mode 00 moves data whenever no conflict
// RL2: Mode 00 ignores every interrupt
// RL3: Masking never alters the interrupt enable bits
// RL4: Mode 01 holds read until enabled interrupt
// RL5: Mode 01 masks interrupts after trigger
// RL6: Mode 10 reads at once, ignoring interrupts
// RL7: Mode 10 holds write until enabled interrupt
// RL8: Mode 11 starts read on enabled interrupt
// RL9: Mode 11 writes on next enabled interrupt
// RL10: Channel yields to all pipeline units
// RL11: Masking released after synchronized write
module dma_sync_ctrl
    import dma_sync_pkg::*;
#(
    parameter int INT_WIDTH = INT_SRC_WIDTH
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [1:0] syncMode,
    input wire logic [INT_WIDTH-1:0] intEnable,
    input wire logic [INT_WIDTH-1:0] intPending,
    input wire logic start,
    input wire logic [ADDR_WIDTH-1:0] srcAddr,
    input wire logic [ADDR_WIDTH-1:0] dstAddr,
    input wire unit_busy_t unitBusy,
    output mem_req_t rdReq,
    input wire logic rdDone,
    input wire logic [DATA_WIDTH-1:0] rdData,
    output mem_req_t wrReq,
    input wire logic wrDone,
    output logic intMasked,
    output logic [INT_WIDTH-1:0] intEnableView,
    output logic busy,
    output logic xferDone
);

    initial begin
        if (INT_WIDTH < 1 || INT_WIDTH > 32) $error("INT_WIDTH out of range");
    end

    // ************************************************************
    // Helpers
    // ************************************************************
    // Enabled interrupt seen, ignoring the global mask
    function automatic logic enabledInt(input logic [INT_WIDTH-1:0] en,
                                        input logic [INT_WIDTH-1:0] pend);
        enabledInt = |(en & pend);
    endfunction : enabledInt

    // Any higher-priority pipeline unit holds the memory
    function automatic logic cpuBlocks(input unit_busy_t b);
        cpuBlocks = b.execute | b.read | b.decode | b.fetch;
    endfunction : cpuBlocks

    typedef struct packed {
        phase_t phase;
        logic [1:0] mode;
        logic masked;
        logic rdIssued;
        logic wrIssued;
        logic [ADDR_WIDTH-1:0] dstAddr;
        mem_req_t rdReq;
        mem_req_t wrReq;
        logic busy;
        logic done;
        logic [INT_WIDTH-1:0] enView;
    } ctrl_state_t;

    ctrl_state_t state_q;
    ctrl_state_t state_d;

    logic bufInValid;
    logic bufInReady;
    xfer_word_t bufInWord;
    logic bufOutValid;
    logic bufOutReady;
    xfer_word_t bufOutWord;
    logic intHit;
    logic blocked;

    // ************************************************************
    // Word buffer between phases
    // ************************************************************
    // A stalled write phase loses nothing; the read waits for room
    xfer_buffer #(
        .DEPTH(BUF_DEPTH)
    ) u_buf (
        .core_clk(core_clk),
        .rst(rst),
        .inValid(bufInValid),
        .inReady(bufInReady),
        .inWord(bufInWord),
        .outValid(bufOutValid),
        .outReady(bufOutReady),
        .outWord(bufOutWord)
    );

    assign bufInValid = state_q.rdIssued && rdDone;
    assign bufInWord = '{addr: state_q.dstAddr, data: rdData};
    assign bufOutReady = state_q.wrIssued && wrDone;

    // Interrupt seen only while not globally masked; enables untouched
    assign intHit = !state_q.masked && enabledInt(intEnable, intPending);
    assign blocked = cpuBlocks(unitBusy); // RL10

    // ************************************************************
    // Phase sequencing
    // ************************************************************
    always_comb begin
        state_d = state_q;
        state_d.done = 1'b0;
        state_d.enView = intEnable; // RL3
        case (state_q.phase)
            ST_IDLE: begin
                if (start) begin
                    state_d.mode = syncMode;
                    state_d.dstAddr = dstAddr;
                    state_d.busy = 1'b1;
                    state_d.rdReq.addr = srcAddr;
                    case (syncMode)
                        SYNC_NONE: begin
                            state_d.masked = 1'b1; // RL2
                            state_d.phase = ST_READ; // RL1
                        end
                        SYNC_DST: begin
                            state_d.masked = 1'b1; // RL6
                            state_d.phase = ST_READ; // RL6
                        end
                        default: begin
                            // Source and both: open for the trigger
                            state_d.masked = 1'b0;
                            state_d.phase = ST_WAIT_RD_INT; // RL4 RL8
                        end
                    endcase
                end
            end
            ST_WAIT_RD_INT: begin
                if (intHit) begin
                    // RL5: source mode locks out further interrupts
                    state_d.masked = (state_q.mode == SYNC_SRC);
                    state_d.phase = ST_READ; // RL4 RL8
                end
            end
            ST_READ: begin
                // Issue only when no CPU unit contends and buffer has room
                if (!state_q.rdIssued && !blocked && bufInReady) begin
                    state_d.rdReq.req = 1'b1; // RL10
                    state_d.rdIssued = 1'b1;
                end else if (state_q.rdIssued) begin
                    state_d.rdReq.req = 1'b0;
                end
                if (state_q.rdIssued && rdDone) begin
                    state_d.rdIssued = 1'b0;
                    state_d.rdReq.req = 1'b0;
                    if (state_q.mode == SYNC_NONE || state_q.mode == SYNC_SRC) begin
                        state_d.phase = ST_WRITE; // RL1
                    end else begin
                        state_d.masked = 1'b0; // RL7 RL9
                        state_d.phase = ST_WAIT_WR_INT;
                    end
                end
            end
            ST_WAIT_WR_INT: begin
                if (intHit) begin
                    state_d.masked = 1'b1;
                    state_d.phase = ST_WRITE; // RL7 RL9
                end
            end
            ST_WRITE: begin
                if (!state_q.wrIssued && !blocked && bufOutValid) begin
                    state_d.wrReq.req = 1'b1; // RL10
                    state_d.wrReq.addr = bufOutWord.addr;
                    state_d.wrReq.data = bufOutWord.data;
                    state_d.wrIssued = 1'b1;
                end else if (state_q.wrIssued) begin
                    state_d.wrReq.req = 1'b0;
                end
                if (state_q.wrIssued && wrDone) begin
                    state_d.wrIssued = 1'b0;
                    state_d.wrReq.req = 1'b0;
                    // Unsynchronized mode keeps ignoring interrupts
                    state_d.masked = (state_q.mode == SYNC_NONE); // RL11
                    state_d.busy = 1'b0;
                    state_d.done = 1'b1;
                    state_d.phase = ST_IDLE;
                end
            end
            default: begin
                state_d.phase = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    // All straight from flip-flops
    assign rdReq = state_q.rdReq;
    assign wrReq = state_q.wrReq;
    assign intMasked = state_q.masked;
    assign intEnableView = state_q.enView;
    assign busy = state_q.busy;
    assign xferDone = state_q.done;

endmodule : dma_sync_ctrl

// ==== test/dma_sync_checker.sv ====
// Port assertions for the DMA sync controller.
// Assumes a bind onto dma_sync_ctrl, one clock, async reset.
module dma_sync_checker
    import dma_sync_pkg::*;
#(
    parameter int INT_WIDTH = INT_SRC_WIDTH
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [1:0] syncMode,
    input wire logic [INT_WIDTH-1:0] intEnable,
    input wire logic [INT_WIDTH-1:0] intPending,
    input wire logic start,
    input wire unit_busy_t unitBusy,
    input wire mem_req_t rdReq,
    input wire logic rdDone,
    input wire mem_req_t wrReq,
    input wire logic intMasked,
    input wire logic [INT_WIDTH-1:0] intEnableView,
    input wire logic busy,
    input wire logic xferDone
);
    timeunit 1ns;
    timeprecision 100ps;
    // ****
    // Helpers
    // ****
    // Interrupt the channel may take now
    wire logic hit = |(intEnable & intPending) && !intMasked;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence hitLately;
        $past(hit) || $past(hit, 2) || $past(hit, 3);
    endsequence
    sequence freeStart;
        start && !busy && !syncMode[0] && unitBusy == '0;
    endsequence
    // ****
    // Assertions
    // ****
    view_copy_a: assert property (!$past(rst) |-> intEnableView == $past(intEnable))
        else $error("enable view differs");
    none_masked_a: assert property (busy && $past(busy) && syncMode == SYNC_NONE |-> intMasked)
        else $error("free mode not masked");
    free_read_a: assert property (freeStart |-> ##[1:2] rdReq.req)
        else $error("free read late");
    rd_gate_a: assert property (rdReq.req && syncMode[0] |-> hitLately)
        else $error("read without interrupt");
    src_mask_a: assert property (rdReq.req && syncMode == SYNC_SRC |-> intMasked)
        else $error("source mode not masked");
    wr_gate_a: assert property (wrReq.req && syncMode[1] |-> hitLately)
        else $error("write without interrupt");
    wr_follow_a: assert property (rdDone && !syncMode[1] && unitBusy == '0 |-> ##[1:2] wrReq.req)
        else $error("write late");
    yield_a: assert property (rdReq.req || wrReq.req |-> $past(unitBusy) == '0)
        else $error("issued over busy unit");
    // Free mode keeps ignoring interrupts after its write, so only synced modes release
    release_a: assert property (xferDone && syncMode != SYNC_NONE |-> !busy && !intMasked)
        else $error("mask kept after done");
endmodule : dma_sync_checker

bind dma_sync_ctrl dma_sync_checker #(.INT_WIDTH(INT_WIDTH)) u_dma_sync_checker (
    .core_clk(core_clk), .rst(rst), .syncMode(syncMode), .intEnable(intEnable),
    .intPending(intPending), .start(start), .unitBusy(unitBusy), .rdReq(rdReq),
    .rdDone(rdDone), .wrReq(wrReq), .intMasked(intMasked),
    .intEnableView(intEnableView), .busy(busy), .xferDone(xferDone));

// ==== test/mem_model.sv ====
// Memory partner: answers read and write request pulses.
// Assumes one-cycle request pulses; slow adds three wait cycles.
module mem_model
    import dma_sync_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic slow,
    input wire mem_req_t rdReq,
    input wire mem_req_t wrReq,
    output logic rdDone,
    output logic [DATA_WIDTH-1:0] rdData,
    output logic wrDone
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0] rdWait, wrWait;
    logic rdOn, wrOn;
    logic [ADDR_WIDTH-1:0] rdAddr;
    // Data toggles outside done so a stale word never matches
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            {rdDone, wrDone, rdOn, wrOn, rdWait, wrWait, rdAddr, rdData} <= '0;
        end else begin
            rdDone <= 1'h0;
            wrDone <= 1'h0;
            rdData <= ~rdData;
            if (rdReq.req) begin
                rdOn <= 1'h1;
                rdWait <= slow ? 2'h3 : 2'h0;
                rdAddr <= rdReq.addr;
            end else if (rdOn && rdWait != 2'h0) begin
                rdWait <= rdWait - 2'h1;
            end else if (rdOn) begin
                rdOn <= 1'h0;
                rdDone <= 1'h1;
                rdData <= {8'hA5, rdAddr};
            end
            if (wrReq.req) begin
                wrOn <= 1'h1;
                wrWait <= slow ? 2'h3 : 2'h0;
            end else if (wrOn && wrWait != 2'h0) begin
                wrWait <= wrWait - 2'h1;
            end else if (wrOn) begin
                wrOn <= 1'h0;
                wrDone <= 1'h1;
            end
        end
    end
endmodule : mem_model

// ==== test/tb.sv ====
// Testbench for dma_sync_ctrl with a memory partner.
// Assumes the checker is bound by its own file.
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import dma_sync_pkg::*;
    typedef struct packed {
        logic [1:0] mode;
        logic [3:0] en;
        logic [3:0] pend;
        logic [5:0] exp;
    } row_t;
    logic core_clk, rst, start, rdDone, wrDone, intMasked, busy, xferDone, slow;
    logic [1:0] syncMode;
    logic [3:0] intEnable, intPending, intEnableView;
    logic [23:0] srcAddr, dstAddr;
    logic [31:0] rdData;
    unit_busy_t unitBusy;
    mem_req_t rdReq, wrReq, wrSeen;
    int bad_count = 0, compares = 0, cycles = 0, rdCnt, wrCnt, doneCnt, tag = 0;
    // Expected read/write counts after each of three phases
    row_t rows [6] = '{'{SYNC_NONE, 4'h3, 4'h2, 6'b11_11_11}, '{SYNC_SRC, 4'h2, 4'h2, 6'b00_11_11},
        '{SYNC_SRC, 4'h1, 4'h2, 6'b00_00_11}, '{SYNC_DST, 4'h2, 4'h2, 6'b10_11_11},
        '{SYNC_BOTH, 4'h2, 4'h2, 6'b00_10_11}, '{SYNC_BOTH, 4'h8, 4'h8, 6'b00_10_11}};
    dma_sync_ctrl u_dma_sync_ctrl (.core_clk(core_clk), .rst(rst), .syncMode(syncMode),
        .intEnable(intEnable), .intPending(intPending), .start(start), .srcAddr(srcAddr),
        .dstAddr(dstAddr), .unitBusy(unitBusy), .rdReq(rdReq), .rdDone(rdDone),
        .rdData(rdData), .wrReq(wrReq), .wrDone(wrDone), .intMasked(intMasked),
        .intEnableView(intEnableView), .busy(busy), .xferDone(xferDone));
    mem_model u_mem_model (.core_clk(core_clk), .rst(rst), .slow(slow), .rdReq(rdReq),
        .wrReq(wrReq), .rdDone(rdDone), .rdData(rdData), .wrDone(wrDone));
    initial begin
        core_clk = 1'h0;
        forever #2.5 core_clk = ~core_clk;
    end
    // Monitor and hang guard; ceiling is several times the planned run
    always @(posedge core_clk) begin
        cycles++;
        if (rdReq.req) rdCnt++;
        if (wrReq.req) begin
            wrCnt++;
            wrSeen = wrReq;
        end
        if (xferDone) doneCnt++;
        if (cycles == 3000) begin
            bad_count++;
            stop_test();
        end
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check
    // One transfer in three phases: none, pulse p, pulse en
    task xfer(input logic [1:0] m, input logic [3:0] en, input logic [3:0] p,
              input logic [5:0] exp);
        rdCnt = 0;
        wrCnt = 0;
        doneCnt = 0;
        tag++;
        syncMode <= m;
        intEnable <= en;
        srcAddr <= 24'h10_0000 | 24'(tag);
        dstAddr <= 24'h20_0000 | 24'(tag);
        start <= 1'h1;
        @(posedge core_clk);
        start <= 1'h0;
        for (int ph = 0; ph < 3; ph++) begin
            if (ph > 0) intPending <= (ph == 1) ? p : en;
            @(posedge core_clk);
            intPending <= 4'h0;
            repeat (11) @(posedge core_clk);
            check(rdCnt, 32'(exp[5-2*ph]));
            check(wrCnt, 32'(exp[4-2*ph]));
        end
        check(doneCnt, 32'h1);
        check(32'(wrSeen.addr), 32'(dstAddr));
        check(wrSeen.data, {8'hA5, srcAddr});
        check(32'(intEnableView), 32'(en));
    endtask : xfer
    task stop_test();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : stop_test
    // Main sequence: table rows, then stalls, slow memory, mid-run reset
    initial begin
        {rst, start, syncMode, intEnable, intPending, srcAddr, dstAddr, unitBusy} = '1;
        {start, intPending, unitBusy, slow} = '0;
        repeat (16) @(posedge core_clk);
        rst <= 1'h0;
        foreach (rows[i]) begin
            xfer(rows[i].mode, rows[i].en, rows[i].pend, rows[i].exp);
            $display("row %0d done", i);
        end
        for (int b = 0; b < 4; b++) begin
            unitBusy <= unit_busy_t'(4'h1 << b);
            fork
                xfer(SYNC_NONE, 4'h1, 4'h1, 6'b11_11_11);
                begin
                    repeat (2) @(posedge core_clk);
                    start <= 1'h1;
                    @(posedge core_clk);
                    start <= 1'h0;
                    check(rdCnt, 32'h0);
                    unitBusy <= '0;
                end
            join
            $display("stall %0d done", b);
        end
        slow <= 1'h1;
        fork
            xfer(SYNC_DST, 4'h2, 4'h0, 6'b10_10_11);
            begin
                repeat (3) @(posedge core_clk);
                intPending <= 4'h2;
                @(posedge core_clk);
                intPending <= 4'h0;
            end
        join
        $display("slow read done");
        syncMode <= SYNC_NONE;
        start <= 1'h1;
        @(posedge core_clk);
        start <= 1'h0;
        rst <= 1'h1;
        @(posedge core_clk);
        #1;
        check({busy, intMasked, rdReq.req, xferDone}, 32'h0);
        rst <= 1'h0;
        $display("reset done");
        stop_test();
    end
endmodule : tb
